// ===== core/acsd_pkg.sv
/*
 * Package for the command decoder: opcodes, monitoring subcommands, attribute
 * identifiers, record layout and command-block carrier types.
 * Assumes a single core clock domain and no software-visible registers.
 */
package acsd_pkg;
    localparam int ACSD_OPC_W = 8;
    localparam int ACSD_CNT_W = 32;
    localparam int ACSD_REC_BYTES = 12;
    localparam int ACSD_NUM_ATTR = 16;
    localparam int ACSD_IDX_W = 4;

    // Opcodes
    localparam logic [7:0] ACSD_OP_RD_DMA = 8'hc8;
    localparam logic [7:0] ACSD_OP_RD_DMA_EXT = 8'h25;
    localparam logic [7:0] ACSD_OP_RD_QUEUED = 8'h60;
    localparam logic [7:0] ACSD_OP_WR_QUEUED = 8'h61;
    localparam logic [7:0] ACSD_OP_WR_DMA = 8'hca;
    localparam logic [7:0] ACSD_OP_WR_DMA_EXT = 8'h35;
    localparam logic [7:0] ACSD_OP_IDENTIFY = 8'hec;
    localparam logic [7:0] ACSD_OP_MONITOR = 8'hb0;
    localparam logic [7:0] ACSD_OP_TRUST_RX = 8'h5c;
    localparam logic [7:0] ACSD_OP_TRUST_RX_DMA = 8'h5d;
    localparam logic [7:0] ACSD_OP_TRUST_TX = 8'h5e;
    localparam logic [7:0] ACSD_OP_TRUST_TX_DMA = 8'h5f;

    // Monitoring subcommands
    localparam logic [7:0] ACSD_SUB_RD_DATA = 8'hd0;
    localparam logic [7:0] ACSD_SUB_RD_THRESH = 8'hd1;
    localparam logic [7:0] ACSD_SUB_AUTOSAVE = 8'hd2;
    localparam logic [7:0] ACSD_SUB_OFFLINE = 8'hd4;
    localparam logic [7:0] ACSD_SUB_RD_LOG = 8'hd5;
    localparam logic [7:0] ACSD_SUB_WR_LOG = 8'hd6;
    localparam logic [7:0] ACSD_SUB_ENABLE = 8'hd8;
    localparam logic [7:0] ACSD_SUB_DISABLE = 8'hd9;
    localparam logic [7:0] ACSD_SUB_STATUS = 8'hda;

    // Attribute identifiers; the initial bad block id is a fixed constant, 8'h05
    localparam logic [7:0] ACSD_ID_INIT_BAD = 8'h05;
    localparam logic [7:0] ACSD_ID_POWER_HOURS = 8'h09;
    localparam logic [7:0] ACSD_ID_POWER_CYCLES = 8'h0c;
    localparam logic [7:0] ACSD_ID_MAX_ERASE = 8'ha3;
    localparam logic [7:0] ACSD_ID_AVG_ERASE = 8'ha4;
    localparam logic [7:0] ACSD_ID_LATER_BAD = 8'ha6;
    localparam logic [7:0] ACSD_ID_PROTECT = 8'ha7;
    localparam logic [7:0] ACSD_ID_PHY_ERR = 8'ha8;
    localparam logic [7:0] ACSD_ID_PROG_FAIL = 8'hab;
    localparam logic [7:0] ACSD_ID_ERASE_FAIL = 8'hac;
    localparam logic [7:0] ACSD_ID_BAD_CLUSTER = 8'haf;
    localparam logic [7:0] ACSD_ID_POWER_LOSS = 8'hc0;
    localparam logic [7:0] ACSD_ID_TEMP = 8'hc2;
    localparam logic [7:0] ACSD_ID_LIFE_LEFT = 8'he7;
    localparam logic [7:0] ACSD_ID_SECT_WR = 8'hf1;

    // Record layout, byte positions
    localparam int ACSD_B_ID = 0;
    localparam int ACSD_B_FLAGS = 1;
    localparam int ACSD_B_VALUE = 3;
    localparam int ACSD_B_WORST = 4;
    localparam int ACSD_B_RAW = 5;
    localparam int ACSD_RAW_BYTES = 7;
    localparam logic [15:0] ACSD_FLAGS_RST = 16'h0000;
    localparam logic [7:0] ACSD_VALUE_RST = 8'h64;
    localparam logic ACSD_MON_EN_RST = 1'b1;
    localparam logic ACSD_AUTOSAVE_RST = 1'b0;

    typedef enum logic [3:0] {
        ACSD_ACT_NONE = 4'h0,
        ACSD_ACT_READ = 4'h1,
        ACSD_ACT_WRITE = 4'h2,
        ACSD_ACT_IDENTIFY = 4'h3,
        ACSD_ACT_TRUSTED = 4'h4,
        ACSD_ACT_MON_DATA = 4'h5,
        ACSD_ACT_MON_THRESH = 4'h6,
        ACSD_ACT_MON_AUTOSAVE = 4'h7,
        ACSD_ACT_MON_OFFLINE = 4'h8,
        ACSD_ACT_MON_RD_LOG = 4'h9,
        ACSD_ACT_MON_WR_LOG = 4'ha,
        ACSD_ACT_MON_ENABLE = 4'hb,
        ACSD_ACT_MON_DISABLE = 4'hc,
        ACSD_ACT_MON_STATUS = 4'hd
    } acsd_act_e;

    typedef enum logic [1:0] {
        ACSD_ST_IDLE = 2'b00,
        ACSD_ST_DECODE = 2'b01,
        ACSD_ST_DONE = 2'b11
    } acsd_state_e;

    typedef struct packed {
        logic [7:0] feature;
        logic [15:0] count;
        logic [47:0] lba;
        logic [7:0] device;
    } acsd_params_s;

    typedef struct packed {
        acsd_act_e action;
        logic aborted;
        logic queued;
    } acsd_result_s;

    typedef struct packed {
        logic init_bad;
        logic later_bad;
        logic prog_fail;
        logic erase_fail;
        logic power_cycle;
        logic power_loss;
        logic hour_tick;
        logic phy_err;
        logic bad_cluster;
        logic sect_wr;
    } acsd_events_s;
endpackage : acsd_pkg

// ===== core/acsd_attr_store.sv
/*
 * Health attribute store: saturating raw counters and gauges, formatted as
 * 12-byte records on request by table index.
 * Assumes event strobes are single-cycle pulses from logic on mclk.
 */
`timescale 1ns/1ps
module acsd_attr_store #(
    parameter int CNT_W = acsd_pkg::ACSD_CNT_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Events and gauges
    input wire acsd_pkg::acsd_events_s events,
    input wire logic [CNT_W-1:0] max_erase,
    input wire logic [CNT_W-1:0] avg_erase,
    input wire logic [7:0] temperature,
    input wire logic [7:0] life_left,
    input wire logic protect_mode,
    // Record read
    input wire logic [acsd_pkg::ACSD_IDX_W-1:0] rec_idx,
    output logic [8*acsd_pkg::ACSD_REC_BYTES-1:0] rec_q
);
    import acsd_pkg::*;

    localparam int NCNT = 10;
    logic [CNT_W-1:0] cnt_q [NCNT];
    logic [NCNT-1:0] ev;
    logic [8*ACSD_REC_BYTES-1:0] rec_d;

    assign ev = {events.sect_wr, events.bad_cluster, events.phy_err, events.hour_tick,
                 events.power_loss, events.power_cycle, events.erase_fail,
                 events.prog_fail, events.later_bad, events.init_bad};

    // Counters stick at all ones so a wrap never hides accumulated wear
    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        return (&v) ? v : v + CNT_W'(1);
    endfunction : sat_inc

    function automatic logic [8*ACSD_REC_BYTES-1:0] pack_rec(input logic [7:0] id,
                                                            input logic [CNT_W-1:0] raw);
        logic [8*ACSD_REC_BYTES-1:0] r;
        r = '0;
        r[8*ACSD_B_ID +: 8] = id;
        r[8*ACSD_B_FLAGS +: 16] = ACSD_FLAGS_RST;
        r[8*ACSD_B_VALUE +: 8] = ACSD_VALUE_RST;
        r[8*ACSD_B_WORST +: 8] = ACSD_VALUE_RST;
        r[8*ACSD_B_RAW +: CNT_W] = raw;
        return r;
    endfunction : pack_rec

    always_ff @(posedge mclk) begin
        for (int i = 0; i < NCNT; i++) begin
            if (!rst_n) begin
                cnt_q[i] <= '0;
            end else if (ev[i]) begin
                cnt_q[i] <= sat_inc(cnt_q[i]);
            end
        end
    end

    always_comb begin
        case (rec_idx)
            4'h0: rec_d = pack_rec(ACSD_ID_INIT_BAD, cnt_q[0]);
            4'h1: rec_d = pack_rec(ACSD_ID_POWER_HOURS, cnt_q[6]);
            4'h2: rec_d = pack_rec(ACSD_ID_POWER_CYCLES, cnt_q[4]);
            4'h3: rec_d = pack_rec(ACSD_ID_MAX_ERASE, max_erase);
            4'h4: rec_d = pack_rec(ACSD_ID_AVG_ERASE, avg_erase);
            4'h5: rec_d = pack_rec(ACSD_ID_LATER_BAD, cnt_q[1]);
            4'h6: rec_d = pack_rec(ACSD_ID_PROTECT, CNT_W'(protect_mode));
            4'h7: rec_d = pack_rec(ACSD_ID_PHY_ERR, cnt_q[7]);
            4'h8: rec_d = pack_rec(ACSD_ID_PROG_FAIL, cnt_q[2]);
            4'h9: rec_d = pack_rec(ACSD_ID_ERASE_FAIL, cnt_q[3]);
            4'ha: rec_d = pack_rec(ACSD_ID_BAD_CLUSTER, cnt_q[8]);
            4'hb: rec_d = pack_rec(ACSD_ID_POWER_LOSS, cnt_q[5]);
            4'hc: rec_d = pack_rec(ACSD_ID_TEMP, CNT_W'(temperature));
            4'hd: rec_d = pack_rec(ACSD_ID_LIFE_LEFT, CNT_W'(life_left));
            4'he: rec_d = pack_rec(ACSD_ID_SECT_WR, cnt_q[9]);
            default: rec_d = '0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rec_q <= '0;
        end else begin
            rec_q <= rec_d;
        end
    end
endmodule : acsd_attr_store

// ===== core/acsd_decoder.sv
/*
 * Command decoder top: takes an opcode write with its command block, classifies
 * it, dispatches monitoring subcommands and reports done with abort status.
 * Assumes the command block is stable when cmd_wr is pulsed; all inputs on mclk.
 * Assumes the host waits for done before the next opcode write.
 */
`timescale 1ns/1ps
module acsd_decoder #(
    parameter bit HAS_ENCRYPTION = 1'b0,
    parameter int CNT_W = acsd_pkg::ACSD_CNT_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Command block and opcode write
    input wire acsd_pkg::acsd_params_s params,
    input wire logic [7:0] opcode,
    input wire logic cmd_wr,
    output logic cmd_busy,
    // Command completion
    output logic done,
    output acsd_pkg::acsd_result_s result_q,
    output logic mon_enabled_q,
    output logic autosave_q,
    // Attribute inputs
    input wire acsd_pkg::acsd_events_s events,
    input wire logic [CNT_W-1:0] max_erase,
    input wire logic [CNT_W-1:0] avg_erase,
    input wire logic [7:0] temperature,
    input wire logic [7:0] life_left,
    input wire logic protect_mode,
    // Attribute record read
    input wire logic [acsd_pkg::ACSD_IDX_W-1:0] rec_idx,
    output logic [8*acsd_pkg::ACSD_REC_BYTES-1:0] rec_q
);
    import acsd_pkg::*;

    acsd_state_e state_q;
    acsd_state_e state_d;
    logic [7:0] opc_q;
    acsd_params_s par_q;
    acsd_result_s res_d;
    logic cmd_take;
    logic in_decode;

    // Subcommand to action; anything unlisted falls through to an abort
    function automatic acsd_act_e mon_decode(input logic [7:0] sub);
        case (sub)
            ACSD_SUB_RD_DATA: begin
                return ACSD_ACT_MON_DATA;
            end
            ACSD_SUB_RD_THRESH: begin
                return ACSD_ACT_MON_THRESH;
            end
            ACSD_SUB_AUTOSAVE: begin
                return ACSD_ACT_MON_AUTOSAVE;
            end
            ACSD_SUB_OFFLINE: begin
                return ACSD_ACT_MON_OFFLINE;
            end
            ACSD_SUB_RD_LOG: begin
                return ACSD_ACT_MON_RD_LOG;
            end
            ACSD_SUB_WR_LOG: begin
                return ACSD_ACT_MON_WR_LOG;
            end
            ACSD_SUB_ENABLE: begin
                return ACSD_ACT_MON_ENABLE;
            end
            ACSD_SUB_DISABLE: begin
                return ACSD_ACT_MON_DISABLE;
            end
            ACSD_SUB_STATUS: begin
                return ACSD_ACT_MON_STATUS;
            end
            default: begin
                return ACSD_ACT_NONE;
            end
        endcase
    endfunction : mon_decode

    // Opcode to action; only the listed codes are recognised
    function automatic acsd_act_e op_decode(input logic [7:0] op, input logic [7:0] sub);
        case (op)
            ACSD_OP_RD_DMA, ACSD_OP_RD_DMA_EXT, ACSD_OP_RD_QUEUED: begin
                return ACSD_ACT_READ;
            end
            ACSD_OP_WR_DMA, ACSD_OP_WR_DMA_EXT, ACSD_OP_WR_QUEUED: begin
                return ACSD_ACT_WRITE;
            end
            ACSD_OP_IDENTIFY: begin
                return ACSD_ACT_IDENTIFY;
            end
            ACSD_OP_TRUST_RX, ACSD_OP_TRUST_RX_DMA, ACSD_OP_TRUST_TX, ACSD_OP_TRUST_TX_DMA: begin
                // Without the encryption engine these end like unknown codes
                return HAS_ENCRYPTION ? ACSD_ACT_TRUSTED : ACSD_ACT_NONE;
            end
            ACSD_OP_MONITOR: begin
                return mon_decode(sub);
            end
            default: begin
                return ACSD_ACT_NONE;
            end
        endcase
    endfunction : op_decode

    // Only the native queued codes carry a queue tag
    function automatic logic is_queued(input logic [7:0] op);
        return (op == ACSD_OP_RD_QUEUED) || (op == ACSD_OP_WR_QUEUED);
    endfunction : is_queued

    // Busy refuses a new opcode; the host must wait for done
    assign cmd_busy = (state_q != ACSD_ST_IDLE);
    assign cmd_take = (state_q == ACSD_ST_IDLE) && cmd_wr;
    assign in_decode = (state_q == ACSD_ST_DECODE);

    // Fixed walk of take, decode, done; no wait state is ever inserted
    always_comb begin
        state_d = state_q;
        case (state_q)
            ACSD_ST_IDLE: begin
                if (cmd_wr) begin
                    state_d = ACSD_ST_DECODE;
                end
            end
            ACSD_ST_DECODE: begin
                state_d = ACSD_ST_DONE;
            end
            ACSD_ST_DONE: begin
                state_d = ACSD_ST_IDLE;
            end
            default: begin
                state_d = ACSD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= ACSD_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Parameters are captured together with the opcode, so later writes cannot race it
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            opc_q <= 8'h00;
            par_q <= '0;
        end else if (cmd_take) begin
            opc_q <= opcode;
            par_q <= params;
        end
    end

    always_comb begin
        res_d.action = op_decode(opc_q, par_q.feature);
        res_d.queued = is_queued(opc_q);
        res_d.aborted = (res_d.action == ACSD_ACT_NONE);
    end

    // Result holds until the next command is decoded
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            result_q <= '{action: ACSD_ACT_NONE, aborted: 1'b0, queued: 1'b0};
        end else if (in_decode) begin
            result_q <= res_d;
        end
    end

    // Monitoring stays on from reset until a disable subcommand arrives
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mon_enabled_q <= ACSD_MON_EN_RST;
        end else if (in_decode) begin
            if (res_d.action == ACSD_ACT_MON_ENABLE) begin
                mon_enabled_q <= 1'b1;
            end else if (res_d.action == ACSD_ACT_MON_DISABLE) begin
                mon_enabled_q <= 1'b0;
            end
        end
    end

    // Autosave takes its on/off from the low byte of the sector count
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            autosave_q <= ACSD_AUTOSAVE_RST;
        end else if (in_decode && res_d.action == ACSD_ACT_MON_AUTOSAVE) begin
            autosave_q <= (par_q.count[7:0] != 8'h00);
        end
    end

    // Done is a one-cycle pulse straight from the state register
    assign done = (state_q == ACSD_ST_DONE);

    acsd_attr_store #(
        .CNT_W(CNT_W)
    ) u_attr (
        .mclk(mclk),
        .rst_n(rst_n),
        .events(events),
        .max_erase(max_erase),
        .avg_erase(avg_erase),
        .temperature(temperature),
        .life_left(life_left),
        .protect_mode(protect_mode),
        .rec_idx(rec_idx),
        .rec_q(rec_q)
    );
endmodule : acsd_decoder

// ===== sim/acsd_properties.sv
/* Port checks for the command decoder.
   Bound to the decoder top in the bench; one clock domain, encryption off. */
`timescale 1ns/1ps
module acsd_props (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Command side
    input wire acsd_pkg::acsd_params_s params,
    input wire logic [7:0] opcode,
    input wire logic cmd_wr,
    input wire logic cmd_busy,
    input wire logic done,
    input wire acsd_pkg::acsd_result_s result_q,
    input wire logic mon_enabled_q,
    // Record read
    input wire logic [3:0] rec_idx,
    input wire logic [95:0] rec_q
);
    import acsd_pkg::*;
    logic take;
    logic mon;
    assign take = cmd_wr && !cmd_busy;
    assign mon = take && opcode == 8'hb0;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    chk_done_latency:
        assert property (take |-> !done ##1 !done ##1 done) else $error("done late");
    chk_busy_span:
        assert property (take |=> cmd_busy [*2] ##1 !cmd_busy) else $error("busy span");
    chk_identify_act:
        assert property (take && opcode == 8'hec |-> ##2 result_q.action == ACSD_ACT_IDENTIFY)
            else $error("identify");
    chk_trusted_abort:
        assert property (take && opcode[7:2] == 6'h17 |-> ##2 result_q.aborted)
            else $error("trusted");
    chk_mon_enable:
        assert property (mon && params.feature == 8'hd8 |-> ##2 mon_enabled_q)
            else $error("enable");
    chk_mon_disable:
        assert property (mon && params.feature == 8'hd9 |-> ##3 !mon_enabled_q)
            else $error("disable");
    chk_abort_none:
        assert property (done |-> result_q.aborted == (result_q.action == ACSD_ACT_NONE))
            else $error("abort flag");
    chk_record_id:
        assert property (rst_n && rec_idx == 4'h2 |=> rec_q[7:0] == 8'h0c)
            else $error("record id");
    chk_record_fixed:
        assert property (rst_n && rec_idx != 4'hf |=> rec_q[39:8] == 32'h6464_0000
            && rec_q[95:72] == '0)
            else $error("record layout");
endmodule : acsd_props

// ===== sim/acsd_host_model.sv
/* Host controller model: loads the command block, then writes the opcode.
   Assumes done pulses a few cycles after the write. */
`timescale 1ns/1ps
module acsd_host_model (
    // Clock
    input wire logic mclk,
    // Command block and opcode write
    output acsd_pkg::acsd_params_s params,
    output logic [7:0] opcode,
    output logic cmd_wr,
    // Completion
    input wire logic done,
    input wire acsd_pkg::acsd_result_s result_q
);
    import acsd_pkg::*;
    initial begin
        params = '0;
        opcode = 8'h00;
        cmd_wr = 1'b0;
    end
    // The opcode write launches execution, so the block settles a cycle earlier
    task automatic issue(input logic [7:0] op, input logic [7:0] sub, input logic [15:0] cnt,
                         output acsd_result_s res, output logic seen);
        seen = 1'b0;
        @(posedge mclk);
        params <= '{feature: sub, count: cnt, lba: 48'h1000, device: 8'h40};
        @(posedge mclk);
        opcode <= op;
        cmd_wr <= 1'b1;
        @(posedge mclk);
        cmd_wr <= 1'b0;
        opcode <= ~op;
        for (int n = 0; n < 6 && !seen; n++) begin
            @(negedge mclk);
            seen = (done === 1'b1);
        end
        res = result_q;
        @(posedge mclk);
    endtask : issue
endmodule : acsd_host_model

// ===== sim/acsd_decoder_test.sv
/* Bench for the command decoder: records, event counters, opcodes, monitoring.
   Assumes the host model drives the command side. */
`timescale 1ns/1ps
module acsd_decoder_test;
    import acsd_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    acsd_params_s params;
    logic [7:0] opcode;
    logic cmd_wr;
    logic cmd_busy;
    logic done;
    acsd_result_s result_q;
    logic mon_enabled_q;
    logic autosave_q;
    acsd_events_s events = '0;
    logic [7:0] max_erase = 8'h5a;
    logic [7:0] avg_erase = 8'h3c;
    logic [7:0] temperature = 8'h2d;
    logic [7:0] life_left = 8'h61;
    logic protect_mode = 1'b1;
    logic [3:0] rec_idx = 4'h0;
    logic [95:0] rec_q;
    acsd_result_s res;
    logic seen;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    always #20 mclk = ~mclk;
    acsd_host_model host_u (.mclk(mclk), .params(params), .opcode(opcode), .cmd_wr(cmd_wr),
        .done(done), .result_q(result_q));
    // Eight-bit counters so saturation is reached in a few hundred events
    acsd_decoder #(.CNT_W(8)) dut_u (.mclk(mclk), .rst_n(rst_n), .params(params),
        .opcode(opcode), .cmd_wr(cmd_wr), .cmd_busy(cmd_busy), .done(done),
        .result_q(result_q), .mon_enabled_q(mon_enabled_q), .autosave_q(autosave_q),
        .events(events), .max_erase(max_erase), .avg_erase(avg_erase),
        .temperature(temperature), .life_left(life_left), .protect_mode(protect_mode),
        .rec_idx(rec_idx), .rec_q(rec_q));
    task automatic check(input logic [95:0] s, input logic [95:0] e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
    endtask : do_reset
    task automatic check_records(input logic [7:0] cnt, input logic stag);
        // Index 15 is unused and must read back as an all-zero record
        logic [7:0] ids [16] = '{8'h05, 8'h09, 8'h0c, 8'ha3, 8'ha4, 8'ha6, 8'ha7, 8'ha8,
                                 8'hab, 8'hac, 8'haf, 8'hc0, 8'hc2, 8'he7, 8'hf1, 8'h00};
        // Counts left by the staggered pulses, one per record
        logic [7:0] add [16] = '{8'h0a, 8'h04, 8'h06, 8'h00, 8'h00, 8'h09, 8'h00, 8'h03,
                                 8'h08, 8'h07, 8'h02, 8'h05, 8'h00, 8'h00, 8'h01, 8'h00};
        logic [7:0] raw;
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk);
            rec_idx <= 4'(i);
            repeat (2) @(posedge mclk);
            @(negedge mclk);
            case (i)
                3: raw = max_erase;
                4: raw = avg_erase;
                6: raw = {7'h00, protect_mode};
                12: raw = temperature;
                13: raw = life_left;
                15: raw = 8'h00;
                default: raw = stag ? add[i] : cnt;
            endcase
            check(96'(rec_q[7:0]), 96'(ids[i]));
            check(96'(rec_q[39:8]), (i == 15) ? 96'h0 : 96'h6464_0000);
            check(96'(rec_q[95:40]), 96'(raw));
        end
    endtask : check_records
    task automatic pulse_events(input int n, input logic [9:0] mask);
        repeat (n) begin
            @(posedge mclk);
            events <= mask;
            @(posedge mclk);
            events <= '0;
        end
    endtask : pulse_events
    task automatic run_cmd(input logic [7:0] op, input logic [7:0] sub, input logic [15:0] cnt,
                           input logic [3:0] act);
        host_u.issue(op, sub, cnt, res, seen);
        check(96'({seen, res}), 96'({1'b1, act, act == 4'h0, op[7:1] == 7'h30}));
    endtask : run_cmd
    task automatic t_opcodes();
        // Low nibble is the expected action; trusted codes abort on this build
        logic [11:0] tab [13] = '{12'hc81, 12'h251, 12'h601, 12'h612, 12'hca2, 12'h352,
            12'hec3, 12'h5c0, 12'h5d0, 12'h5e0, 12'h5f0, 12'he50, 12'h000};
        for (int i = 0; i < 13; i++) begin
            run_cmd(tab[i][11:4], 8'h00, 16'h0008, tab[i][3:0]);
        end
    endtask : t_opcodes
    task automatic t_monitor();
        logic [11:0] tab [11] = '{12'hd05, 12'hd16, 12'hd27, 12'hd48, 12'hd59, 12'hd6a,
            12'hd9c, 12'hd8b, 12'hdad, 12'hd30, 12'hd27};
        for (int i = 0; i < 11; i++) begin
            run_cmd(8'hb0, tab[i][11:4], 16'(i != 10), tab[i][3:0]);
            check(96'({mon_enabled_q, autosave_q}), 96'({i != 6, i >= 2 && i < 10}));
        end
    endtask : t_monitor
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        do_reset();
        check_records(8'h00, 1'b0);
        // Event k pulses k+1 times so that each counter record shows its own count
        for (int b = 0; b < 10; b++) begin
            pulse_events(b + 1, 10'h001 << b);
        end
        check_records(8'h00, 1'b1);
        {max_erase, avg_erase, temperature, life_left, protect_mode} <= 33'h1_fe80_0000;
        pulse_events(300, 10'h3ff);
        check_records(8'hff, 1'b0);
        t_opcodes();
        t_monitor();
        // A reset in mid-run must clear every counter again
        do_reset();
        check_records(8'h00, 1'b0);
        conclude();
    end
endmodule : acsd_decoder_test
bind acsd_decoder acsd_props props_u (.mclk(mclk), .rst_n(rst_n), .params(params),
    .opcode(opcode), .cmd_wr(cmd_wr), .cmd_busy(cmd_busy), .done(done),
    .result_q(result_q), .mon_enabled_q(mon_enabled_q), .rec_idx(rec_idx), .rec_q(rec_q));
